// ---- core/sadc_pkg.sv ----
package sadc_pkg;
	// converter resolution and channel count
	localparam int RES_BITS = 12;
	localparam int NUM_CH = 8;
	// converter clock limit and conversion length
	localparam int CLK_MAX_HZ = 18_000_000;
	localparam int CONV_MIN_CLKS = 18;
	// system clock rate
	localparam int SYS_CLK_HZ = 50_000_000;
	// divider so the converter clock never exceeds the limit (rounds up)
	localparam int CONV_DIV = (SYS_CLK_HZ + CLK_MAX_HZ - 1) / CLK_MAX_HZ;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_INT_MASK = 8'h08;
	localparam logic [7:0] REG_LIMIT_LO = 8'h0c;
	localparam logic [7:0] REG_LIMIT_HI = 8'h10;
	localparam logic [7:0] REG_CH_EN = 8'h14;
	localparam logic [7:0] REG_MANUAL_CH = 8'h18;
	localparam logic [7:0] REG_SAMPLE_BASE = 8'h20;
	localparam logic [7:0] REG_RESULT_BASE = 8'h40;
	// ctrl field positions
	localparam int CTRL_START = 0;
	localparam int CTRL_CONT = 1;
	localparam int CTRL_MANUAL = 2;
	localparam int CTRL_STOP = 3;
	// status / mask field positions
	localparam int ST_DONE = 0;
	localparam int ST_RANGE = 1;
	localparam int ST_BUSY = 2;
	localparam int ST_CH_LSB = 4;
	// default sample time in converter clocks
	localparam logic [7:0] SAMPLE_RST = 8'h03;
	// sequencer states
	typedef enum logic [2:0] {
		SADC_IDLE = 3'b001,
		SADC_SAMPLE = 3'b010,
		SADC_CONVERT = 3'b100
	} sadc_state_t;
endpackage : sadc_pkg

// ---- core/sadc_sar_core.sv ----
`timescale 1ns/1ns
// successive approximation engine: one bit per converter tick
module sadc_sar_core #(
	parameter int RES = 12,
	parameter int CONV_CLKS = 18
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic tick_i,
	input wire logic start_i,
	input wire logic cmp_i,
	output logic [RES-1:0] dac_o,
	output logic done_o,
	output logic [RES-1:0] result_o
);
	initial
	begin
		if (CONV_CLKS < RES + 1)
			$error("conversion too short for resolution");
	end
	// tick counter inside one conversion
	logic [7:0] step;
	// conversion in progress
	logic busy;
	// trial register
	logic [RES-1:0] trial;
	// bit index under test
	logic [7:0] bit_idx;

	assign dac_o = trial;

	// step through the bits, then pad to the full clock count
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			busy <= 1'b0;
			step <= 8'h00;
			trial <= '0;
			bit_idx <= 8'h00;
			done_o <= 1'b0;
			result_o <= '0;
		end
		else if (ce_i)
		begin
			done_o <= 1'b0;
			if (start_i && !busy)
			begin
				busy <= 1'b1;
				step <= 8'h00;
				bit_idx <= 8'(RES - 1);
				trial <= '0;
				trial[RES-1] <= 1'b1;
			end
			else if (busy && tick_i)
			begin
				step <= step + 8'h01;
				// step zero only lets the first trial reach the synchronised comparator
				// decide one bit on each of the next RES ticks
				if (step != 8'h00 && step <= 8'(RES))
				begin
					if (!cmp_i)
						trial[bit_idx[3:0]] <= 1'b0;
					if (bit_idx != 8'h00)
					begin
						trial[bit_idx[3:0] - 4'h1] <= 1'b1;
						bit_idx <= bit_idx - 8'h01;
					end
				end
				// result only after the full conversion length
				if (step == 8'(CONV_CLKS - 1))
				begin
					busy <= 1'b0;
					done_o <= 1'b1;
					result_o <= trial;
				end
			end
		end
	end

	// result only after the full conversion length
	conv_len_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$past(ce_i) && done_o |-> $past(busy) && $past(step) == 8'(CONV_CLKS - 1))
		else $error("conversion too short");
endmodule : sadc_sar_core

// ---- core/sadc_seq.sv ----
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
// Operation
// - twelve bit results, converter clock at most 18MHz
// - conversion takes at least 18 converter clocks
// - sequencer selects among eight input channels
// - scan walks enabled channels without software
// - channel change adds no idle cycles
// - state machine scan or firmware channel select
// - one result buffer per channel
// - per channel sample time applied
// - programmable low and high limits
// - out of range interrupt outside window
// - limit check on each result
// - acquisition window length programmable
// - inoperative while deep sleep removes clock
module sadc_seq #(
	parameter int NCH = sadc_pkg::NUM_CH
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic deep_sleep_i,
	input wire logic cmp_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic [2:0] mux_sel_o,
	output logic sample_o,
	output logic [11:0] dac_o,
	output logic irq_o
);
	localparam int RB = sadc_pkg::RES_BITS;
	initial
	begin
		if (NCH != 8)
			$error("channel count must be eight");
	end

	// config registers
	logic [NCH-1:0] ch_en;
	logic cont;
	logic manual;
	logic [2:0] manual_ch;
	logic [RB-1:0] limit_lo;
	logic [RB-1:0] limit_hi;
	logic [1:0] int_mask;
	logic [1:0] int_stat;
	// per channel sample times and result buffers
	logic [7:0] sample_time [NCH];
	logic [RB-1:0] result_buf [NCH];
	// sequencer
	sadc_pkg::sadc_state_t state;
	logic [2:0] cur_ch;
	logic [7:0] samp_cnt;
	logic conv_start;
	logic conv_done;
	logic [RB-1:0] conv_res;
	logic [11:0] dac_w;
	// converter clock tick
	logic [7:0] div_cnt;
	logic tick;
	// synchronised sleep and comparator pins
	logic [1:0] sleep_sync;
	logic [1:0] cmp_sync;
	// decoded bus events and converter result events
	logic start_w;
	logic stop_w;
	logic done_ev;
	logic range_ev;
	// mode bit of the starting write, first enabled and following channel
	logic start_manual;
	logic [3:0] first_ch;
	logic [3:0] next_w;

	// next enabled channel after c, wrapping; c when it is alone, 8 when none
	function automatic logic [3:0] next_ch(input logic [2:0] c, input logic [NCH-1:0] en);
		logic [3:0] r;
		logic [2:0] k;
		r = 4'h8;
		for (int i = NCH; i >= 1; i--)
		begin
			k = 3'(c + 3'(i));
			if (en[k])
				r = {1'b0, k};
		end
		return r;
	endfunction : next_ch

	// window check
	function automatic logic out_of_range(input logic [RB-1:0] v, input logic [RB-1:0] lo,
		input logic [RB-1:0] hi);
		return (v < lo) || (v > hi);
	endfunction : out_of_range

	assign start_w = wr_i && addr_i == sadc_pkg::REG_CTRL && wdata_i[sadc_pkg::CTRL_START];
	assign stop_w = wr_i && addr_i == sadc_pkg::REG_CTRL && wdata_i[sadc_pkg::CTRL_STOP];
	assign start_manual = wdata_i[sadc_pkg::CTRL_MANUAL];
	assign first_ch = next_ch(3'h7, ch_en);
	assign next_w = next_ch(cur_ch, ch_en);
	// trial code straight from its register: one more stage would leave the
	// comparator answer a cycle late at the next tick
	assign dac_o = dac_w;

	// two stage sync of the pin inputs
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			sleep_sync <= 2'b00;
			cmp_sync <= 2'b00;
		end
		else if (ce_i)
		begin
			sleep_sync <= {sleep_sync[0], deep_sleep_i};
			cmp_sync <= {cmp_sync[0], cmp_i};
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			div_cnt <= 8'h00;
			tick <= 1'b0;
		end
		else if (ce_i)
		begin
			tick <= div_cnt == 8'(sadc_pkg::CONV_DIV - 1);
			if (div_cnt == 8'(sadc_pkg::CONV_DIV - 1))
				div_cnt <= 8'h00;
			else
				div_cnt <= div_cnt + 8'h01;
		end
	end

	sadc_sar_core #(
		.RES(RB),
		.CONV_CLKS(sadc_pkg::CONV_MIN_CLKS)
	) u_sar (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.tick_i(tick),
		.start_i(conv_start),
		.cmp_i(cmp_sync[1]),
		.dac_o(dac_w),
		.done_o(conv_done),
		.result_o(conv_res)
	);

	// register writes
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			ch_en <= '0;
			cont <= 1'b0;
			manual <= 1'b0;
			manual_ch <= 3'h0;
			limit_lo <= '0;
			limit_hi <= '1;
			int_mask <= 2'b00;
			for (int i = 0; i < NCH; i++)
				sample_time[i] <= sadc_pkg::SAMPLE_RST;
		end
		else if (ce_i && wr_i)
		begin
			unique case (addr_i)
				sadc_pkg::REG_CTRL:
				begin
					cont <= wdata_i[sadc_pkg::CTRL_CONT];
					manual <= wdata_i[sadc_pkg::CTRL_MANUAL];
				end
				sadc_pkg::REG_INT_MASK: int_mask <= wdata_i[1:0];
				sadc_pkg::REG_LIMIT_LO: limit_lo <= wdata_i[RB-1:0];
				sadc_pkg::REG_LIMIT_HI: limit_hi <= wdata_i[RB-1:0];
				sadc_pkg::REG_CH_EN: ch_en <= wdata_i[NCH-1:0];
				sadc_pkg::REG_MANUAL_CH: manual_ch <= wdata_i[2:0];
				default:
				begin
					if (addr_i[7:5] == sadc_pkg::REG_SAMPLE_BASE[7:5])
						sample_time[addr_i[4:2]] <= wdata_i[7:0];
				end
			endcase
		end
	end

	// sequencer state machine
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			state <= sadc_pkg::SADC_IDLE;
			cur_ch <= 3'h0;
			samp_cnt <= 8'h00;
			conv_start <= 1'b0;
			done_ev <= 1'b0;
		end
		else if (ce_i)
		begin
			conv_start <= 1'b0;
			done_ev <= 1'b0;
			if (sleep_sync[1] || stop_w)
				state <= sadc_pkg::SADC_IDLE;
			else
				unique case (state)
					sadc_pkg::SADC_IDLE:
					begin
						// mode bit of the starting write counts, not the old register
						if (start_w && (start_manual || ch_en != '0))
						begin
							cur_ch <= start_manual ? manual_ch : first_ch[2:0];
							samp_cnt <= 8'h00;
							state <= sadc_pkg::SADC_SAMPLE;
						end
					end
					sadc_pkg::SADC_SAMPLE:
					begin
						// sample time of the current channel
						if (tick)
						begin
							if (samp_cnt >= sample_time[cur_ch])
							begin
								conv_start <= 1'b1;
								state <= sadc_pkg::SADC_CONVERT;
							end
							else
								samp_cnt <= samp_cnt + 8'h01;
						end
					end
					sadc_pkg::SADC_CONVERT:
					begin
						if (conv_done)
						begin
							samp_cnt <= 8'h00;
							// autonomous step goes straight into next sample; manual or end of scan idles unless cont
							if (manual)
							begin
								done_ev <= 1'b1;
								state <= cont ? sadc_pkg::SADC_SAMPLE : sadc_pkg::SADC_IDLE;
								cur_ch <= manual_ch;
							end
							else if (next_w <= {1'b0, cur_ch} || next_w == 4'h8)
							begin
								done_ev <= 1'b1;
								state <= cont ? sadc_pkg::SADC_SAMPLE : sadc_pkg::SADC_IDLE;
								cur_ch <= first_ch[2:0];
							end
							else
							begin
								cur_ch <= next_w[2:0];
								state <= sadc_pkg::SADC_SAMPLE;
							end
						end
					end
					default: state <= sadc_pkg::SADC_IDLE;
				endcase
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			range_ev <= 1'b0;
			for (int i = 0; i < NCH; i++)
				result_buf[i] <= '0;
		end
		else if (ce_i)
		begin
			range_ev <= 1'b0;
			if (conv_done)
			begin
				result_buf[cur_ch] <= conv_res;
				range_ev <= out_of_range(conv_res, limit_lo, limit_hi);
			end
		end
	end

	// sticky status; set wins over read clear
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			int_stat <= 2'b00;
		else if (ce_i)
		begin
			if (rd_i && addr_i == sadc_pkg::REG_STATUS)
				int_stat <= {range_ev, done_ev};
			else
				int_stat <= int_stat | {range_ev, done_ev};
		end
	end

	// read data and outputs, all registered
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			rdata_o <= 32'h0000_0000;
			irq_o <= 1'b0;
			mux_sel_o <= 3'h0;
			sample_o <= 1'b0;
		end
		else if (ce_i)
		begin
			irq_o <= |(int_stat & int_mask);
			mux_sel_o <= cur_ch;
			sample_o <= state == sadc_pkg::SADC_SAMPLE;
			rdata_o <= 32'h0000_0000;
			if (rd_i)
			begin
				unique case (addr_i)
					sadc_pkg::REG_CTRL: rdata_o <= 32'({manual, cont, 1'b0});
					sadc_pkg::REG_STATUS:
						rdata_o <= 32'({cur_ch, 1'b0, state != sadc_pkg::SADC_IDLE, int_stat});
					sadc_pkg::REG_INT_MASK: rdata_o <= 32'(int_mask);
					sadc_pkg::REG_LIMIT_LO: rdata_o <= 32'(limit_lo);
					sadc_pkg::REG_LIMIT_HI: rdata_o <= 32'(limit_hi);
					sadc_pkg::REG_CH_EN: rdata_o <= 32'(ch_en);
					sadc_pkg::REG_MANUAL_CH: rdata_o <= 32'(manual_ch);
					default:
					begin
						if (addr_i[7:5] == sadc_pkg::REG_SAMPLE_BASE[7:5])
							rdata_o <= 32'(sample_time[addr_i[4:2]]);
						else if (addr_i[7:5] == sadc_pkg::REG_RESULT_BASE[7:5])
							rdata_o <= 32'(result_buf[addr_i[4:2]]);
					end
				endcase
			end
		end
	end

	irq_level_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i |=> irq_o == |($past(int_stat) & $past(int_mask)))
		else $error("irq level wrong");
	samp_order_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$past(ce_i) && conv_start |-> $past(state) == sadc_pkg::SADC_SAMPLE)
		else $error("conversion without sample");
	range_time_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$past(ce_i) && range_ev |-> $past(conv_done))
		else $error("range event late");
	sleep_idle_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && sleep_sync[1] |=> state == sadc_pkg::SADC_IDLE)
		else $error("active in sleep");
	// each result lands in its own channel buffer
	buf_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && conv_done |=> result_buf[$past(cur_ch)] == $past(conv_res))
		else $error("result buffer not written");
	scan_done_c: cover property (@(posedge sys_clk_i) done_ev);
	range_c: cover property (@(posedge sys_clk_i) range_ev);
	manual_c: cover property (@(posedge sys_clk_i) manual && conv_done);
endmodule : sadc_seq

// ---- verification/sadc_analog_src.sv ----
`timescale 1ns/1ns
// far side: eight analog sources behind one sample and hold
module sadc_analog_src (
	input wire logic sys_clk_i,
	input wire logic [7:0][11:0] level_i,
	input wire logic [2:0] mux_sel_i,
	input wire logic sample_i,
	input wire logic [11:0] dac_i,
	output logic cmp_o
);
	// voltage frozen on the hold cap
	logic [11:0] held = 12'h000;
	// cap tracks the selected pin only while the switch is closed
	always @(posedge sys_clk_i)
	begin
		if (sample_i)
		begin
			held <= level_i[mux_sel_i];
		end
	end
	// keep the trial bit when held level is not below the trial code
	assign cmp_o = (held >= dac_i);
endmodule : sadc_analog_src

// ---- verification/tb_sar_adc_channel_sequencer.sv ----
`timescale 1ns/1ns
module tb_sar_adc_channel_sequencer;
	// design drive, all set at time zero
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic deep_sleep_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic [2:0] mux_sel_o;
	logic sample_o;
	logic [11:0] dac_o;
	logic irq_o;
	logic cmp_i;
	// analog level on each pin
	logic [7:0][11:0] level = '0;
	int err_count = 0;
	int n_tests = 0;
	// sample phase length, its channel, and the gap before it
	int scnt = 0;
	int gcnt = 0;
	int gap = 0;
	int slen [8];
	logic [2:0] sch = 3'h0;
	logic [31:0] d;
	logic seen;

	always #10 sys_clk_i = ~sys_clk_i;

	sadc_seq dut (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ce_i(1'b1),
		.deep_sleep_i(deep_sleep_i),
		.cmp_i(cmp_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata_o),
		.mux_sel_o(mux_sel_o),
		.sample_o(sample_o),
		.dac_o(dac_o),
		.irq_o(irq_o)
	);

	sadc_analog_src src (
		.sys_clk_i(sys_clk_i),
		.level_i(level),
		.mux_sel_i(mux_sel_o),
		.sample_i(sample_o),
		.dac_i(dac_o),
		.cmp_o(cmp_i)
	);

	// measure each sample phase and the conversion gap ahead of it
	always @(posedge sys_clk_i)
	begin
		if (sample_o === 1'b1)
		begin
			if (scnt == 0)
				gap <= gcnt;
			scnt <= scnt + 1;
			sch <= mux_sel_o;
			gcnt <= 0;
		end
		else
		begin
			if (scnt != 0)
				slen[sch] <= scnt;
			scnt <= 0;
			gcnt <= gcnt + 1;
		end
	end

	// verdict and end of run
	task automatic end_sim;
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	// one compare for every register or timing result
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// single cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask : rd

	// bounded wait for the interrupt line
	task automatic wait_irq;
		// a status clear by the last read needs two edges to reach the pin
		repeat (2) @(posedge sys_clk_i);
		for (int i = 0; i < 4000 && irq_o !== 1'b1; i++)
			@(posedge sys_clk_i);
		if (irq_o !== 1'b1)
		begin
			err_count++;
			$display("ERROR %0t interrupt never came", $time);
			end_sim();
		end
	endtask : wait_irq

	initial
	begin
		repeat (10) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		rd(sadc_pkg::REG_LIMIT_HI, d); chk(d, 32'hfff);
		rd(sadc_pkg::REG_SAMPLE_BASE, d); chk(d, {24'h0, sadc_pkg::SAMPLE_RST});
		rd(8'h1c, d); chk(d, 32'h0);
		// two channel scan, results buffered per channel
		level[0] <= 12'h123;
		level[2] <= 12'habc;
		wr(sadc_pkg::REG_INT_MASK, 32'h1);
		wr(sadc_pkg::REG_CH_EN, 32'h5);
		wr(sadc_pkg::REG_CTRL, 32'h1);
		wait_irq();
		rd(sadc_pkg::REG_STATUS, d); chk(d & 32'h7, 32'h1);
		rd(sadc_pkg::REG_RESULT_BASE, d); chk(d, 32'h123);
		rd(sadc_pkg::REG_RESULT_BASE + 8'h08, d); chk(d, 32'habc);
		// longer sample time on channel two; both compared phases follow a conversion
		wr(sadc_pkg::REG_SAMPLE_BASE + 8'h08, 32'ha);
		wr(sadc_pkg::REG_CH_EN, 32'h7);
		wr(sadc_pkg::REG_CTRL, 32'h1);
		wait_irq();
		rd(sadc_pkg::REG_STATUS, d);
		chk(slen[2] - slen[1], 7 * sadc_pkg::CONV_DIV);
		chk(gap >= 18 * sadc_pkg::CONV_DIV && gap <= 21 * sadc_pkg::CONV_DIV, 1);
		// low side trips mid scan, high side trips at the end
		level[2] <= 12'h900;
		wr(sadc_pkg::REG_LIMIT_LO, 32'h200);
		wr(sadc_pkg::REG_LIMIT_HI, 32'h800);
		wr(sadc_pkg::REG_INT_MASK, 32'h2);
		wr(sadc_pkg::REG_CH_EN, 32'h5);
		wr(sadc_pkg::REG_CTRL, 32'h1);
		wait_irq();
		rd(sadc_pkg::REG_STATUS, d); chk(d & 32'h6, 32'h6);
		wr(sadc_pkg::REG_INT_MASK, 32'h1);
		wait_irq();
		rd(sadc_pkg::REG_STATUS, d); chk(d & 32'h3, 32'h3);
		wr(sadc_pkg::REG_LIMIT_LO, 32'h0);
		wr(sadc_pkg::REG_LIMIT_HI, 32'hfff);
		// firmware picks the channel
		level[5] <= 12'h7e5;
		wr(sadc_pkg::REG_MANUAL_CH, 32'h5);
		wr(sadc_pkg::REG_CTRL, 32'h5);
		wait_irq();
		rd(sadc_pkg::REG_STATUS, d);
		rd(sadc_pkg::REG_RESULT_BASE + 8'h14, d); chk(d, 32'h7e5);
		// continuous scan restarts by itself until stopped
		level[0] <= 12'h5a5;
		wr(sadc_pkg::REG_CH_EN, 32'h1);
		wr(sadc_pkg::REG_CTRL, 32'h3);
		wait_irq();
		rd(sadc_pkg::REG_STATUS, d);
		wait_irq();
		rd(sadc_pkg::REG_STATUS, d); chk(d & 32'h1, 32'h1);
		wr(sadc_pkg::REG_CTRL, 32'h8);
		rd(sadc_pkg::REG_RESULT_BASE, d); chk(d, 32'h5a5);
		repeat (100) @(posedge sys_clk_i);
		// deep sleep: a start must not reach the converter
		deep_sleep_i <= 1'b1;
		repeat (5) @(posedge sys_clk_i);
		wr(sadc_pkg::REG_CTRL, 32'h1);
		seen = 1'b0;
		repeat (300)
		begin
			@(posedge sys_clk_i);
			if (sample_o !== 1'b0)
				seen = 1'b1;
		end
		chk({31'h0, seen}, 32'h0);
		rd(sadc_pkg::REG_STATUS, d); chk(d & 32'h4, 32'h0);
		end_sim();
	end
endmodule : tb_sar_adc_channel_sequencer
